// ---- pkg/usr_consts.vh ----
`ifndef USR_CONSTS_VH
`define USR_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define USR_OFF_RX_CTRL   8'h18
`define USR_OFF_TX_CTRL   8'h20
`define USR_OFF_DIVISOR   8'h24
`define USR_OFF_RX_DATA   8'h28
`define USR_OFF_INT_STAT  8'h2C
`define USR_OFF_INT_MASK  8'h30
`define USR_OFF_PIN_DIR   8'h34

// ****************************************************************
// Receive status and control fields
// ****************************************************************
`define USR_RC_SERIAL_PORT_ENABLE   7
`define USR_RC_RX9    6
`define USR_RC_SINGLE_RECEIVE_ENABLE   5
`define USR_RC_CONTINUOUS_RECEIVE_ENABLE   4
`define USR_RC_FRAMING_ERROR_FLAG   2
`define USR_RC_OVERRUN_ERROR_FLAG   1
`define USR_RC_RECEIVED_NINTH_BIT   0

// ****************************************************************
// Transmit status and control fields used here
// ****************************************************************
`define USR_TC_CSRC   7
`define USR_TC_SYNC   4
`define USR_TC_HIGH_SPEED_SELECT   2

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define USR_INT_RXD   0
`define USR_INT_OVR   1
`define USR_INT_FRM   2

// ****************************************************************
// Baud timer ticks per bit, minus one
// ****************************************************************
`define USR_LEN_ASYNC_LO  6'h3F
`define USR_LEN_ASYNC_HI  6'h0F
`define USR_LEN_SYNC      6'h03

// ****************************************************************
// Bus answers and reset values
// ****************************************************************
`define USR_RESP_OKAY    2'h0
`define USR_RESP_SLVERR  2'h2
`define USR_RST_BYTE     8'h00

`endif

// ---- hw/usr_rx_brg.v ----
// Function
// - One free running 8-bit baud timer, all modes
// - Divisor register sets the timer period
// - Async low speed: osc/(64*(div+1))
// - Async high speed: osc/(16*(div+1))
// - Sync: osc/(4*(div+1)), speed select ignored
// - Speed select ignored in synchronous mode
// - Sync: divisor rate only when master makes clock; async always uses it
// - Divisor write clears the baud timer immediately
// - Async: three mid-bit samples, majority decides bit; sync samples once per bit
// - Pins serve port only when enabled and directed
`timescale 1ns/1ps
`include "usr_consts.vh"

module usr_rx_brg #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              rst_n,
  // AXI4-Lite write address and data
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Serial line
  input  wire              rx_dt_in,
  input  wire              ck_in,
  output reg               ck_out,
  output reg               ck_oe,
  // Interrupt
  output reg               irq
);

  // ****************************************************************
  // Receiver states
  // ****************************************************************
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_START = 2'd1;
  localparam [1:0] ST_DATA  = 2'd2;
  localparam [1:0] ST_STOP  = 2'd3;

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg              serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q;  // Control bits
  reg              framing_error_flag_q, overrun_error_flag_q, received_ninth_bit_q;         // Status bits
  reg              csrc_q, sync_q, high_speed_select_q;          // Mode bits
  reg [7:0]        div_q;                           // Baud divisor
  reg [7:0]        brg_cnt_q;                       // Baud timer
  reg [1:0]        pin_dir_q;                       // Pin directions
  reg [7:0]        rdata_q;                         // Received byte
  reg              full_q;                          // Byte unread
  reg [2:0]        int_stat_q;                      // Sticky events
  reg [2:0]        int_mask_q;                      // Event enables
  reg [1:0]        st_q;                            // Receiver state
  reg [5:0]        ph_q;                            // Ticks in bit
  reg [3:0]        bit_q;                           // Bits received
  reg [1:0]        vote_q;                          // High samples
  reg [8:0]        sh_q;                            // Shift register
  reg              ck_prev_q;                       // Slave clock
  reg              aw_ok_q, w_ok_q;                 // Write halves held
  reg [ADDR_W-1:0] waddr_q;                         // Held address
  reg [7:0]        wdata_q;                         // Held data
  reg              wstrb0_q;                        // Low lane enabled

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Address matches a register offset
  function hit;
    input [ADDR_W-1:0] a;
    input [7:0]        off;
    begin
      hit = (a[7:0] == off);
    end
  endfunction

  // Address lands on any mapped register
  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = hit(a, `USR_OFF_RX_CTRL) | hit(a, `USR_OFF_TX_CTRL) |
               hit(a, `USR_OFF_DIVISOR) | hit(a, `USR_OFF_RX_DATA) |
               hit(a, `USR_OFF_INT_STAT) | hit(a, `USR_OFF_INT_MASK) |
               hit(a, `USR_OFF_PIN_DIR);
    end
  endfunction

  // ****************************************************************
  // Combinational control
  // ****************************************************************
  wire wr_fire = aw_ok_q & w_ok_q & ~s_axi_bvalid;     // Write now
  wire wr_go   = wr_fire & wstrb0_q;                   // Lane 0 written
  wire ar_hs   = s_axi_arvalid & s_axi_arready;        // Read taken
  wire rd_pop  = ar_hs & hit(s_axi_araddr, `USR_OFF_RX_DATA);
  wire div_wr  = wr_go & hit(waddr_q, `USR_OFF_DIVISOR);
  wire rc_wr   = wr_go & hit(waddr_q, `USR_OFF_RX_CTRL);
  wire master  = sync_q & csrc_q;                      // Makes clock
  wire pins_ok = serial_port_enable_q & (&pin_dir_q);
  // Baud timer period is divisor plus one cycles
  wire tick    = (brg_cnt_q == div_q);
  // Ticks per bit; sync ignores speed select
  wire [5:0] len_m1 = sync_q ? `USR_LEN_SYNC :
                      (high_speed_select_q ? `USR_LEN_ASYNC_HI :
                                `USR_LEN_ASYNC_LO);
  wire [5:0] mid    = len_m1 / 6'd2 + 6'd1;            // Bit centre
  // Receive runs: async on continuous, sync master on either bit,
  // sync slave on continuous only
  wire rx_on   = pins_ok & ~overrun_error_flag_q &
                 (continuous_receive_enable_q | (master & single_receive_enable_q));
  // Sync master samples at end of clock high half
  wire s_samp  = master ? (tick & (ph_q == `USR_LEN_SYNC)) :
                 (ck_in & ~ck_prev_q);
  wire in_win  = (ph_q + 6'd1 == mid) | (ph_q == mid) |
                 (ph_q == mid + 6'd1);
  // Majority including the sample taken this cycle
  wire [1:0] votes = vote_q + {1'b0, in_win & rx_dt_in};
  wire       bitv  = votes[1];
  wire       last  = (bit_q == (rx9_q ? 4'd8 : 4'd7));

  // ****************************************************************
  // Baud timer
  // ****************************************************************
  // Free running count, restarted at once by a divisor write
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_cnt_q <= `USR_RST_BYTE;
    end else if (div_wr || tick) begin
      brg_cnt_q <= `USR_RST_BYTE;
    end else begin
      brg_cnt_q <= brg_cnt_q + 8'h01;
    end
  end

  // ****************************************************************
  // Registers and receiver
  // ****************************************************************
  // Software writes and receive engine share this process
  always @(posedge core_clk or negedge rst_n) begin : rx_proc
    reg       done;
    reg [8:0] shn;
    reg       fe;
    done = 1'b0;
    shn  = sh_q;
    fe   = 1'b0;
    if (!rst_n) begin
      serial_port_enable_q <= 1'b0; rx9_q <= 1'b0; single_receive_enable_q <= 1'b0; continuous_receive_enable_q <= 1'b0;
      framing_error_flag_q <= 1'b0; overrun_error_flag_q <= 1'b0; received_ninth_bit_q <= 1'b0;
      csrc_q <= 1'b0; sync_q <= 1'b0; high_speed_select_q <= 1'b0;
      div_q <= `USR_RST_BYTE; pin_dir_q <= 2'b00;
      rdata_q <= `USR_RST_BYTE; full_q <= 1'b0;
      int_stat_q <= 3'b000; int_mask_q <= 3'b000;
      st_q <= ST_IDLE; ph_q <= 6'h00; bit_q <= 4'h0; vote_q <= 2'b00;
      sh_q <= 9'h000; ck_prev_q <= 1'b0;
      ck_out <= 1'b0; ck_oe <= 1'b0; irq <= 1'b0;
    end else begin
      ck_prev_q <= ck_in;
      // Register writes
      if (rc_wr) begin
        serial_port_enable_q <= wdata_q[`USR_RC_SERIAL_PORT_ENABLE];
        rx9_q  <= wdata_q[`USR_RC_RX9];
        single_receive_enable_q <= wdata_q[`USR_RC_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_q <= wdata_q[`USR_RC_CONTINUOUS_RECEIVE_ENABLE];
        if (!wdata_q[`USR_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
          overrun_error_flag_q <= 1'b0;
        end
      end
      if (wr_go && hit(waddr_q, `USR_OFF_TX_CTRL)) begin
        csrc_q <= wdata_q[`USR_TC_CSRC];
        sync_q <= wdata_q[`USR_TC_SYNC];
        high_speed_select_q <= wdata_q[`USR_TC_HIGH_SPEED_SELECT];
      end
      if (div_wr) begin
        div_q <= wdata_q;
      end
      if (wr_go && hit(waddr_q, `USR_OFF_PIN_DIR)) begin
        pin_dir_q <= wdata_q[1:0];
      end
      if (wr_go && hit(waddr_q, `USR_OFF_INT_MASK)) begin
        int_mask_q <= wdata_q[2:0];
      end
      // Receive engine
      if (!rx_on) begin
        // Abort any character when reception stops
        st_q <= ST_IDLE;
        ph_q <= 6'h00;
      end else if (sync_q) begin
        // Synchronous: data bits only, on the bit clock
        if (st_q == ST_IDLE) begin
          st_q  <= ST_DATA;
          ph_q  <= 6'h00;
          bit_q <= 4'h0;
        end else begin
          if (tick) begin
            ph_q <= ph_q + 6'h01;
            if (ph_q == `USR_LEN_SYNC) begin
              ph_q <= 6'h00;
            end
          end
          if (s_samp) begin
            shn   = {rx_dt_in, sh_q[8:1]};
            bit_q <= bit_q + 4'h1;
            if (last) begin
              done  = 1'b1;
              bit_q <= 4'h0;
              // Single receive ends unless continuous holds on
              if (!continuous_receive_enable_q) begin
                single_receive_enable_q <= 1'b0;
                st_q   <= ST_IDLE;
              end
            end
          end
        end
      end else begin
        // Asynchronous framing
        case (st_q)
          ST_IDLE: begin
            if (!rx_dt_in) begin
              st_q   <= ST_START;
              ph_q   <= 6'h00;
              vote_q <= 2'b00;
            end
          end
          default: begin
            if (tick) begin
              vote_q <= votes;
              ph_q   <= ph_q + 6'h01;
              if (ph_q == len_m1) begin
                ph_q   <= 6'h00;
                vote_q <= 2'b00;
                case (st_q)
                  ST_START: begin
                    // High start bit is a false start
                    st_q  <= bitv ? ST_IDLE : ST_DATA;
                    bit_q <= 4'h0;
                  end
                  ST_DATA: begin
                    shn   = {bitv, sh_q[8:1]};
                    bit_q <= bit_q + 4'h1;
                    if (last) begin
                      st_q <= ST_STOP;
                    end
                  end
                  default: begin
                    done = 1'b1;
                    fe   = ~bitv;
                    st_q <= ST_IDLE;
                  end
                endcase
              end
            end
          end
        endcase
      end
      sh_q <= shn;
      // Character complete: overrun if previous byte still unread
      if (done && full_q && !rd_pop) begin
        overrun_error_flag_q        <= 1'b1;
        int_stat_q[1] <= 1'b1;
      end else if (done) begin
        full_q  <= 1'b1;
        framing_error_flag_q  <= fe;
        // Nine bits fill the register; eight leave it one short
        rdata_q <= rx9_q ? shn[7:0] : shn[8:1];
        received_ninth_bit_q  <= rx9_q & shn[8];
        int_stat_q[`USR_INT_RXD] <= 1'b1;
        if (fe) begin
          int_stat_q[`USR_INT_FRM] <= 1'b1;
        end
      end else if (rd_pop) begin
        full_q <= 1'b0;
      end
      // Write-one clear; a new event in the same cycle wins
      if (wr_go && hit(waddr_q, `USR_OFF_INT_STAT)) begin
        int_stat_q <= (int_stat_q & ~wdata_q[2:0]) |
                      {done & ~(full_q & ~rd_pop) & fe,
                       done & full_q & ~rd_pop,
                       done & ~(full_q & ~rd_pop)};
      end
      irq   <= |(int_stat_q & int_mask_q);
      // Clock pin driven only by an enabled synchronous master
      ck_oe  <= pins_ok & master;
      ck_out <= master & (st_q == ST_DATA) & ph_q[1];
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data taken in either order, answered once both held
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `USR_RESP_OKAY;
      aw_ok_q       <= 1'b0;
      w_ok_q        <= 1'b0;
      waddr_q       <= {ADDR_W{1'b0}};
      wdata_q       <= `USR_RST_BYTE;
      wstrb0_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q       <= 1'b1;
        waddr_q       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q       <= 1'b1;
        wdata_q      <= s_axi_wdata[7:0];
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_ok_q      <= 1'b0;
        w_ok_q       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(waddr_q) ? `USR_RESP_OKAY :
                                          `USR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // One read at a time; data registered the cycle after the address
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `USR_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `USR_RESP_OKAY :
                                                `USR_RESP_SLVERR;
        s_axi_rdata   <= 32'h0000_0000;
        if (hit(s_axi_araddr, `USR_OFF_RX_CTRL)) begin
          s_axi_rdata[7:0] <= {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, 1'b0,
                               framing_error_flag_q, overrun_error_flag_q, received_ninth_bit_q};
        end
        if (hit(s_axi_araddr, `USR_OFF_TX_CTRL)) begin
          s_axi_rdata[`USR_TC_CSRC] <= csrc_q;
          s_axi_rdata[`USR_TC_SYNC] <= sync_q;
          s_axi_rdata[`USR_TC_HIGH_SPEED_SELECT] <= high_speed_select_q;
        end
        if (hit(s_axi_araddr, `USR_OFF_DIVISOR)) begin
          s_axi_rdata[7:0] <= div_q;
        end
        if (hit(s_axi_araddr, `USR_OFF_RX_DATA)) begin
          s_axi_rdata[7:0] <= rdata_q;
        end
        if (hit(s_axi_araddr, `USR_OFF_INT_STAT)) begin
          s_axi_rdata[2:0] <= int_stat_q;
        end
        if (hit(s_axi_araddr, `USR_OFF_INT_MASK)) begin
          s_axi_rdata[2:0] <= int_mask_q;
        end
        if (hit(s_axi_araddr, `USR_OFF_PIN_DIR)) begin
          s_axi_rdata[1:0] <= pin_dir_q;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ---- verification/usr_rx_brg_asserts.sv ----
`timescale 1ns/1ps
`include "usr_consts.vh"

module usr_rx_brg_asserts #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // Write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Interrupt
  input wire logic              irq
);

  // ****
  // Decode and sequences
  // ****
  // True where a register answers
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a == `USR_OFF_RX_CTRL || a == `USR_OFF_TX_CTRL ||
             a == `USR_OFF_DIVISOR || a == `USR_OFF_RX_DATA ||
             a == `USR_OFF_INT_STAT || a == `USR_OFF_INT_MASK ||
             a == `USR_OFF_PIN_DIR;
  endfunction

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Address and data taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Mask register cleared to zero
  sequence s_mask_off;
    s_wr_taken ##0 (s_axi_awaddr == `USR_OFF_INT_MASK &&
                    s_axi_wstrb[0] && s_axi_wdata[7:0] == 8'h00);
  endsequence

  // ****
  // Assertions
  // ****
  a_write_answer: assert property (s_wr_taken |-> ##1 !s_axi_bvalid
    ##1 s_axi_bvalid) else $error("write answer late or early");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_rd_taken |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_aw_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready early");
  a_rd_unmapped: assert property (s_rd_taken ##0 !mapped(s_axi_araddr)
    |=> s_axi_rresp == `USR_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_wr_unmapped: assert property (s_wr_taken ##0 !mapped(s_axi_awaddr)
    |-> ##2 s_axi_bresp == `USR_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_irq_masked: assert property (s_mask_off |-> ##[2:3] !irq)
    else $error("irq high with mask clear");

endmodule

bind usr_rx_brg usr_rx_brg_asserts #(.ADDR_W(ADDR_W)) chk_u (.*);

// ---- verification/usr_peer.sv ----
`timescale 1ns/1ps

module usr_peer (
  // Clock that times async bits
  input wire logic core_clk,
  // Bit clock from the block
  input wire logic ck_out,
  input wire logic ck_oe,
  // Lines toward the block
  output logic     rx_dt_in,
  output logic     ck_in
);
  logic [7:0] sync_sh;  // Byte shifted out in sync mode
  int         sync_cnt; // Bits already shifted
  logic       sync_on;  // Sync byte in progress

  // Idle line high, slave clock still
  initial begin
    rx_dt_in = 1'b1;
    ck_in    = 1'b0;
    sync_on  = 1'b0;
    sync_cnt = 0;
    sync_sh  = 8'h00;
  end

  // One level for n cycles, optionally upset for one mid-bit cycle
  task automatic hold_bit(input logic v, input int n, input logic gl);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_dt_in <= (gl && i == n / 2) ? ~v : v;
    end
  endtask

  // Start, data LSB first, stop; a bad stop is low past mid-bit
  task automatic send_async(input logic [8:0] d, input int nb,
                            input int cyc, input logic stop);
    hold_bit(1'b0, cyc, 1'b0);
    for (int b = 0; b < nb; b++) hold_bit(d[b], cyc, 1'b1);
    if (stop) begin
      hold_bit(1'b1, cyc, 1'b0);
    end else begin
      hold_bit(1'b0, cyc / 2 + 8, 1'b0);
      hold_bit(1'b1, cyc, 1'b0);
    end
  endtask

  // First bit shows before the first rising clock edge
  task automatic load_sync(input logic [7:0] d);
    sync_sh  = d;
    sync_cnt = 0;
    sync_on  = 1'b1;
    rx_dt_in <= d[0];
  endtask

  // Next bit after each falling edge; line inverted once released
  always @(negedge ck_out) begin
    if (sync_on && ck_oe) begin
      sync_cnt = sync_cnt + 1;
      if (sync_cnt == 8) begin
        sync_on = 1'b0;
        rx_dt_in <= ~rx_dt_in;
      end else begin
        rx_dt_in <= sync_sh[sync_cnt];
      end
    end
  end
endmodule

// ---- verification/test_usr_rx_brg.sv ----
`timescale 1ns/1ps
`include "usr_consts.vh"

module test_usr_rx_brg;
  // ****
  // Signals
  // ****
  logic        core_clk, rst_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        rx_dt_in, ck_in, ck_out, ck_oe, irq;
  logic [33:0] rd_q[$];      // Expected {rresp, rdata}
  logic [1:0]  b_q[$];       // Expected bresp
  int          miscompares, total_checks, seed, n, m;
  logic [7:0]  d, e;         // Random bytes

  // 125 MHz clock
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  usr_rx_brg #(.ADDR_W(8)) dut_u (.*);

  usr_peer peer_u (.*);

  // ****
  // Compare, bus and wait tasks
  // ****
  task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_lvl(input logic got, input logic exp);
    cmp_rd(34'(got), 34'(exp));
  endtask

  // One write; expected answer noted first
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r = `USR_RESP_OKAY);
    b_q.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // One read; expected answer noted first
  task automatic rd(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r = `USR_RESP_OKAY);
    rd_q.push_back({r, 24'h00_0000, v});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Cycles until the bit clock shows level v
  task automatic wait_ck(input logic v, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (ck_out !== v && c < 200);
  endtask

  // Oldest note against each answer as it appears
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0)
      cmp_rd({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready && b_q.size() > 0)
      cmp_rd(34'(s_axi_bresp), 34'(b_q.pop_front()));
  end

  task automatic complete_run;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    complete_run;
  end

  // ****
  // Main sequence
  // ****
  initial begin
    seed = 76708;
    miscompares = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
     s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset value, read-only flags, unmapped place
    rd(`USR_OFF_RX_CTRL, 8'h00);
    wr(`USR_OFF_RX_CTRL, 8'h07);
    rd(`USR_OFF_RX_CTRL, 8'h00);
    rd(8'h3C, 8'h00, `USR_RESP_SLVERR);
    wr(8'h3C, 8'hFF, `USR_RESP_SLVERR);
    wr(`USR_OFF_PIN_DIR, 8'h03);
    wr(`USR_OFF_INT_MASK, 8'h07);
    // Async low speed 8 bits, then high speed 9 bits
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      e = $random(seed);
      wr(`USR_OFF_TX_CTRL, i ? 8'h04 : 8'h00);
      wr(`USR_OFF_DIVISOR, i ? 8'h02 : 8'h00);
      wr(`USR_OFF_RX_CTRL, i ? 8'hD0 : 8'h90);
      peer_u.send_async({e[0], d}, 8 + i, i ? 48 : 64, 1'b1);
      repeat (4) @(posedge core_clk);
      cmp_lvl(irq, 1'b1);
      cmp_lvl(ck_oe, 1'b0);
      rd(`USR_OFF_RX_CTRL, i ? {7'h68, e[0]} : 8'h90);
      rd(`USR_OFF_RX_DATA, d);
      wr(`USR_OFF_INT_STAT, 8'h01);
      repeat (3) @(posedge core_clk);
      cmp_lvl(irq, 1'b0);
    end
    // Low stop bit, then cleared by pop and a good byte
    wr(`USR_OFF_RX_CTRL, 8'h90);
    d = $random(seed);
    e = $random(seed);
    peer_u.send_async({1'b0, d}, 8, 48, 1'b0);
    repeat (96) @(posedge core_clk);
    rd(`USR_OFF_RX_CTRL, 8'h94);
    rd(`USR_OFF_RX_DATA, d);
    peer_u.send_async({1'b0, e}, 8, 48, 1'b1);
    repeat (4) @(posedge core_clk);
    rd(`USR_OFF_RX_CTRL, 8'h90);
    rd(`USR_OFF_RX_DATA, e);
    // Two bytes unread: overrun, cleared only with continuous off
    wr(`USR_OFF_INT_STAT, 8'h07);
    d = $random(seed);
    e = $random(seed);
    peer_u.send_async({1'b0, d}, 8, 48, 1'b1);
    peer_u.send_async({1'b0, e}, 8, 48, 1'b1);
    repeat (4) @(posedge core_clk);
    rd(`USR_OFF_RX_CTRL, 8'h92);
    rd(`USR_OFF_INT_STAT, 8'h03);
    rd(`USR_OFF_RX_DATA, d);
    wr(`USR_OFF_RX_CTRL, 8'h80);
    rd(`USR_OFF_RX_CTRL, 8'h80);
    wr(`USR_OFF_INT_MASK, 8'h00);
    wr(`USR_OFF_INT_STAT, 8'h07);
    wr(`USR_OFF_INT_MASK, 8'h07);
    // Sync master single receive, speed select set but ignored
    wr(`USR_OFF_TX_CTRL, 8'h94);
    wr(`USR_OFF_DIVISOR, 8'h01);
    d = $random(seed);
    peer_u.load_sync(d);
    wr(`USR_OFF_RX_CTRL, 8'hA0);
    wait_ck(1'b1, n);
    cmp_lvl(ck_oe, 1'b1);
    wait_ck(1'b0, n);
    wait_ck(1'b1, m);
    cmp_rd(34'(n + m), 34'h0_0000_0008);
    n = 0;
    while (peer_u.sync_on && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    repeat (16) @(posedge core_clk);
    rd(`USR_OFF_RX_CTRL, 8'h80);
    rd(`USR_OFF_RX_DATA, d);
    // Continuous with single set: single bit stays, reception runs
    e = $random(seed);
    peer_u.load_sync(e);
    wr(`USR_OFF_RX_CTRL, 8'hB0);
    n = 0;
    while (peer_u.sync_on && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    rd(`USR_OFF_RX_CTRL, 8'hB0);
    rd(`USR_OFF_RX_DATA, e);
    wr(`USR_OFF_RX_CTRL, 8'h80);
    complete_run;
  end
endmodule
